// *** fqh_pkg.sv ***
package fqh_pkg;

	// Bus widths.
	localparam int          ADDR_W          = 21;
	localparam int          DATA_W          = 16;

	// Command codes and command addresses.
	localparam logic [7:0]  CMD_QUERY       = 8'h98;
	localparam logic [7:0]  CMD_RESET       = 8'hF0;
	localparam logic [20:0] QUERY_ADDR_WORD = 21'h000055;
	localparam logic [20:0] QUERY_ADDR_BYTE = 21'h0000AA;
	localparam logic [20:0] RESET_ADDR      = 21'h000000;

	// Query table window in word offsets.
	localparam logic [6:0]  QRY_FIRST       = 7'h10;
	localparam logic [6:0]  QRY_LAST        = 7'h34;

	// Pin timing in ns and derived cycle counts at 50 MHz.
	localparam int          CLK_PERIOD_NS   = 20;
	localparam int          T_SETUP_NS      = 20;
	localparam int          T_STROBE_NS     = 60;
	localparam int          T_ACCESS_NS     = 80;
	localparam int          T_GLITCH_NS     = 5;
	localparam int          SETUP_CYC       = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          STROBE_CYC      = (T_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          ACCESS_CYC      = (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          GLITCH_CYC      = (T_GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [3:0]  SETUP_CNT       = 4'(SETUP_CYC);
	localparam logic [3:0]  STROBE_CNT      = 4'(STROBE_CYC);
	localparam logic [3:0]  ACCESS_CNT      = 4'(ACCESS_CYC);

	// Host operation codes.
	localparam logic [1:0]  OP_QUERY        = 2'h0;
	localparam logic [1:0]  OP_RESET        = 2'h1;
	localparam logic [1:0]  OP_READ         = 2'h2;

	typedef enum logic [2:0] {
		ST_IDLE   = 3'b000,
		ST_SETUP  = 3'b001,
		ST_STROBE = 3'b010,
		ST_HOLD   = 3'b011,
		ST_ACCESS = 3'b100
	} fqh_state_t;

	// Expected table contents, indexed by word offset.
	function automatic logic [15:0] fqh_expect(input logic [6:0] ofs);
		case (ofs)
			7'h10: fqh_expect = 16'h0051;
			7'h11: fqh_expect = 16'h0052;
			7'h12: fqh_expect = 16'h0059;
			7'h13: fqh_expect = 16'h0002;
			7'h15: fqh_expect = 16'h0040;
			7'h1B: fqh_expect = 16'h0016;
			7'h1C: fqh_expect = 16'h0020;
			7'h1F: fqh_expect = 16'h0004;
			7'h21: fqh_expect = 16'h000A;
			7'h23: fqh_expect = 16'h0005;
			7'h25: fqh_expect = 16'h0004;
			7'h27: fqh_expect = 16'h0015;
			7'h28: fqh_expect = 16'h0002;
			7'h2C: fqh_expect = 16'h0002;
			7'h2D: fqh_expect = 16'h00FF;
			7'h2E: fqh_expect = 16'h0001;
			7'h2F: fqh_expect = 16'h0010;
			7'h31: fqh_expect = 16'h001F;
			7'h34: fqh_expect = 16'h0001;
			default: fqh_expect = 16'h0000;
		endcase
	endfunction

endpackage

// *** fqh_sync.sv ***
`timescale 1ns/1ps
module fqh_sync
	import fqh_pkg::*;
#(
	parameter int W = 16
) (
	// Clock and reset.
	input  wire logic         ref_clk,
	input  wire logic         arst_n,
	// Asynchronous input and synchronised output.
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);

	logic [W-1:0] meta_q;
	logic [W-1:0] meta_d;
	logic [W-1:0] dout_q;
	logic [W-1:0] dout_d;

	always_comb begin
		meta_d = din;
		dout_d = meta_q;
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			meta_q <= '0;
			dout_q <= '0;
		end else begin
			meta_q <= meta_d;
			dout_q <= dout_d;
		end
	end

	assign dout = dout_q;

endmodule // fqh_sync

// *** fqh_host.sv ***
`timescale 1ns/1ps
// Function
// RULE1: Enter query mode by writing 98h to 55h (word) or AAh (byte).
// RULE2: Query reads in word mode drive address bits A7 and above to zero.
// RULE3: Query mode lasts until reset command; device then returns to array read.
// RULE4: Device also accepts query code while in identification mode.
// RULE5: Reset from query entered via identification returns to identification.
// RULE6: Offsets 10h-12h read Q R Y; byte offsets start at 20h.
// RULE7: Offsets 13h-1Ah hold command set, extended pointer 0040h, then zeros.
// RULE8: Offsets 1Bh-1Eh hold supply codes 0016h, 0020h, then zeros.
// RULE9: Typical timeouts: 1Fh=0004h, 21h=000Ah, 20h and 22h zero.
// RULE10: Maximum multipliers: 23h=0005h, 25h=0004h, 24h and 26h zero.
// RULE11: Size 0015h, interface 0002h/0000h, multi-byte write 0000h.
// RULE12: Two erase regions with the listed region descriptor words.
// RULE13: Program or erase only after required unlock cycles.
// RULE14: During supply lockout all writes are rejected and device resets.
// RULE15: Strobe pulses shorter than about 5 ns start no write.
// RULE16: Write inhibited if output enable low, chip select high or strobe high.
// RULE17: Host writes with chip select and strobe low, output enable high.
// RULE18: All three controls low together is treated as a read.
// RULE19: At power-up device is in array read and locks out writes.
// RULE20: Reset command is one write of F0 to any address.
// RULE21: Bad command sequence returns device to array read.
// RULE22: Byte offset is twice word offset; data on low byte, upper zero.
module fqh_host
	import fqh_pkg::*;
(
	// Clock and reset.
	input  wire logic              ref_clk,
	input  wire logic              arst_n,
	// Command port.
	input  wire logic              cmd_valid,
	input  wire logic [1:0]        cmd_op,
	input  wire logic [6:0]        cmd_ofs,
	input  wire logic              byte_mode,
	output logic                   cmd_ready,
	output logic                   rsp_valid,
	output logic [15:0]            rsp_data,
	output logic                   rsp_match,
	// Flash pins.
	output logic [ADDR_W-1:0]      flash_addr,
	output logic                   flash_ce_n,
	output logic                   flash_oe_n,
	output logic                   flash_we_n,
	output logic [DATA_W-1:0]      flash_dq_o,
	output logic                   flash_dq_oe_n,
	input  wire logic [DATA_W-1:0] flash_dq_i
);

	fqh_state_t              st_q,    st_d;
	logic       [3:0]        cnt_q,   cnt_d;
	logic       [1:0]        op_q,    op_d;
	logic       [6:0]        ofs_q,   ofs_d;
	logic                    bm_q,    bm_d;
	logic       [ADDR_W-1:0] addr_q,  addr_d;
	logic                    ce_n_q,  ce_n_d;
	logic                    oe_n_q,  oe_n_d;
	logic                    we_n_q,  we_n_d;
	logic       [DATA_W-1:0] dq_q,    dq_d;
	logic                    dqoe_q,  dqoe_d;
	logic                    rv_q,    rv_d;
	logic       [15:0]       rd_q,    rd_d;
	logic                    rm_q,    rm_d;
	logic                    rdy_q,   rdy_d;
	logic       [DATA_W-1:0] dq_sync;
	logic       [15:0]       rd_val;

	fqh_sync #(.W(DATA_W)) u_sync (
		.ref_clk (ref_clk),
		.arst_n  (arst_n),
		.din     (flash_dq_i),
		.dout    (dq_sync)
	);

	// In byte mode only the low byte is meaningful; the upper lanes carry a changing pattern.
	assign rd_val = bm_q ? {8'h00, dq_sync[7:0]} : dq_sync; // RULE22

	always_comb begin
		st_d   = st_q;
		cnt_d  = cnt_q;
		op_d   = op_q;
		ofs_d  = ofs_q;
		bm_d   = bm_q;
		addr_d = addr_q;
		ce_n_d = ce_n_q;
		oe_n_d = oe_n_q;
		we_n_d = we_n_q;
		dq_d   = dq_q;
		dqoe_d = dqoe_q;
		rv_d   = 1'b0;
		rd_d   = rd_q;
		rm_d   = rm_q;
		rdy_d  = rdy_q;
		case (st_q)
			ST_IDLE: begin
				if (cmd_valid && rdy_q) begin
					rdy_d = 1'b0;
					op_d  = cmd_op;
					ofs_d = cmd_ofs;
					bm_d  = byte_mode;
					cnt_d = SETUP_CNT;
					st_d  = ST_SETUP;
					ce_n_d = 1'b0;
					case (cmd_op)
						OP_QUERY: begin
							addr_d = byte_mode ? QUERY_ADDR_BYTE : QUERY_ADDR_WORD; // RULE1
							dq_d   = {8'h00, CMD_QUERY}; // RULE1
							dqoe_d = 1'b0;
						end
						OP_RESET: begin
							addr_d = RESET_ADDR; // RULE20
							dq_d   = {8'h00, CMD_RESET}; // RULE20 RULE3 RULE5
							dqoe_d = 1'b0;
						end
						default: begin
							// Upper address bits zero; byte offset is twice the word offset.
							addr_d = byte_mode ? {13'h0000, cmd_ofs, 1'b0} : {14'h0000, cmd_ofs}; // RULE2 RULE22 RULE6
							dqoe_d = 1'b1;
							oe_n_d = 1'b0;
						end
					endcase
				end
			end
			ST_SETUP: begin
				if (cnt_q > 4'h1) begin
					cnt_d = cnt_q - 4'h1;
				end else if (op_q == OP_READ) begin
					cnt_d = ACCESS_CNT;
					st_d  = ST_ACCESS;
				end else begin
					// Output enable stays high while strobe is low: a valid write.
					we_n_d = 1'b0; // RULE17 RULE16 RULE18
					cnt_d  = STROBE_CNT;
					st_d   = ST_STROBE;
				end
			end
			ST_STROBE: begin
				// Strobe held for several cycles, far wider than the glitch filter.
				if (cnt_q > 4'h1) begin
					cnt_d = cnt_q - 4'h1; // RULE15
				end else begin
					we_n_d = 1'b1;
					st_d   = ST_HOLD;
				end
			end
			ST_ACCESS: begin
				// Two extra cycles cover the input synchroniser.
				if (cnt_q > 4'h0) begin
					cnt_d = cnt_q - 4'h1;
				end else begin
					rd_d   = rd_val;
					rm_d   = (rd_val == fqh_expect(ofs_q)); // RULE7 RULE8 RULE9 RULE10 RULE11 RULE12
					rv_d   = 1'b1;
					oe_n_d = 1'b1;
					st_d   = ST_HOLD;
				end
			end
			ST_HOLD: begin
				ce_n_d = 1'b1;
				dqoe_d = 1'b1;
				rdy_d  = 1'b1;
				st_d   = ST_IDLE;
			end
			default: begin
				st_d = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_q   <= ST_IDLE;
			cnt_q  <= 4'h0;
			op_q   <= OP_READ;
			ofs_q  <= 7'h00;
			bm_q   <= 1'b0;
			addr_q <= '0;
			ce_n_q <= 1'b1;
			oe_n_q <= 1'b1;
			we_n_q <= 1'b1;
			dq_q   <= '0;
			dqoe_q <= 1'b1;
			rv_q   <= 1'b0;
			rd_q   <= 16'h0000;
			rm_q   <= 1'b0;
			rdy_q  <= 1'b1;
		end else begin
			st_q   <= st_d;
			cnt_q  <= cnt_d;
			op_q   <= op_d;
			ofs_q  <= ofs_d;
			bm_q   <= bm_d;
			addr_q <= addr_d;
			ce_n_q <= ce_n_d;
			oe_n_q <= oe_n_d;
			we_n_q <= we_n_d;
			dq_q   <= dq_d;
			dqoe_q <= dqoe_d;
			rv_q   <= rv_d;
			rd_q   <= rd_d;
			rm_q   <= rm_d;
			rdy_q  <= rdy_d;
		end
	end

	assign cmd_ready     = rdy_q;
	assign rsp_valid     = rv_q;
	assign rsp_data      = rd_q;
	assign rsp_match     = rm_q;
	assign flash_addr    = addr_q;
	assign flash_ce_n    = ce_n_q;
	assign flash_oe_n    = oe_n_q;
	assign flash_we_n    = we_n_q;
	assign flash_dq_o    = dq_q;
	assign flash_dq_oe_n = dqoe_q;

	property p_write_levels;
		@(posedge ref_clk) disable iff (!arst_n)
		!we_n_q |-> (!ce_n_q && oe_n_q && !dqoe_q);
	endproperty
	a_write_levels: assert property (p_write_levels) else $error("Write strobe low without valid levels"); // RULE17

	property p_strobe_width;
		@(posedge ref_clk) disable iff (!arst_n)
		$fell(we_n_q) |-> !we_n_q [*3];
	endproperty
	a_strobe_width: assert property (p_strobe_width) else $error("Write strobe too short"); // RULE15

	property p_query_data;
		@(posedge ref_clk) disable iff (!arst_n)
		(st_q == ST_SETUP && op_q == OP_QUERY) |->
			(dq_q[7:0] == CMD_QUERY && addr_q == (bm_q ? QUERY_ADDR_BYTE : QUERY_ADDR_WORD));
	endproperty
	a_query_data: assert property (p_query_data) else $error("Query command value wrong"); // RULE1

	property p_reset_data;
		@(posedge ref_clk) disable iff (!arst_n)
		(st_q == ST_SETUP && op_q == OP_RESET) |-> dq_q[7:0] == CMD_RESET;
	endproperty
	a_reset_data: assert property (p_reset_data) else $error("Reset command value wrong"); // RULE20

	property p_read_addr;
		@(posedge ref_clk) disable iff (!arst_n)
		(!oe_n_q && !bm_q) |-> addr_q[20:7] == 14'h0000;
	endproperty
	a_read_addr: assert property (p_read_addr) else $error("Upper address bits not zero on query read"); // RULE2

	property p_byte_addr;
		@(posedge ref_clk) disable iff (!arst_n)
		(!oe_n_q && bm_q) |-> (addr_q[0] == 1'b0 && addr_q[7:1] == ofs_q);
	endproperty
	a_byte_addr: assert property (p_byte_addr) else $error("Byte offset not twice word offset"); // RULE22

	property p_no_contention;
		@(posedge ref_clk) disable iff (!arst_n)
		!oe_n_q |-> (we_n_q && dqoe_q);
	endproperty
	a_no_contention: assert property (p_no_contention) else $error("Host drives data during read"); // RULE18

	// The answer registers six edges after the take and is sampled at the seventh.
	property p_read_answer;
		@(posedge ref_clk) disable iff (!arst_n)
		(st_q == ST_IDLE && cmd_valid && rdy_q && cmd_op == OP_READ) |-> ##7 rsp_valid;
	endproperty
	a_read_answer: assert property (p_read_answer) else $error("Read answer late"); // RULE6

	property p_write_release;
		@(posedge ref_clk) disable iff (!arst_n)
		$rose(we_n_q) |=> ce_n_q;
	endproperty
	a_write_release: assert property (p_write_release) else $error("Chip select not released after write"); // RULE16

	c_query: cover property (@(posedge ref_clk) disable iff (!arst_n) st_q == ST_STROBE && op_q == OP_QUERY);
	c_reset: cover property (@(posedge ref_clk) disable iff (!arst_n) st_q == ST_STROBE && op_q == OP_RESET);
	c_match: cover property (@(posedge ref_clk) disable iff (!arst_n) rsp_valid && rsp_match);
	c_byte:  cover property (@(posedge ref_clk) disable iff (!arst_n) rsp_valid && bm_q);

endmodule // fqh_host

// *** fqh_flash_model.sv ***
`timescale 1ns/1ps
module fqh_flash_model #(
	parameter logic [15:0] ID_WORD = 16'h1234, // Identification word; the value is arbitrary.
	parameter realtime     T_ACC   = 60
) (
	// Flash pins.
	input  wire logic [20:0] addr,
	input  wire logic        ce_n,
	input  wire logic        oe_n,
	input  wire logic        we_n,
	input  wire logic [15:0] dq_in,
	output logic      [15:0] dq_out,
	// Strap, mode and supply controls, and the error count.
	input  wire logic        byte_mode,
	input  wire logic        ident_req,
	input  wire logic        lockout,
	output int               errs
);
	localparam logic [7:0] QT [0:36] = '{8'h51, 8'h52, 8'h59, 8'h02, 8'h00, 8'h40, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h16, 8'h20, 8'h00, 8'h00, 8'h04, 8'h00, 8'h0A, 8'h00, 8'h05, 8'h00, 8'h04, 8'h00, 8'h15,
		8'h02, 8'h00, 8'h00, 8'h00, 8'h02, 8'hFF, 8'h01, 8'h10, 8'h00, 8'h1F, 8'h00, 8'h00, 8'h01};
	logic [1:0]  mode;
	logic        from_id;
	logic [19:0] wofs;
	realtime     t_fall;
	// Mode 0 is array read, 1 identification, 2 query.
	initial begin
		mode = 2'h0;
		from_id = 1'b0;
		errs = 0;
		dq_out = 16'h5A5A;
		t_fall = 0;
	end
	assign wofs = byte_mode ? addr[20:1] : addr[19:0];
	function automatic logic [15:0] rd_val();
		logic [15:0] w;
		if (mode == 2'h2) w = (wofs >= 20'h10 && wofs <= 20'h34 && (byte_mode || addr[20:7] == 14'h0)) ?
			{8'h00, QT[wofs - 20'h10]} : ~addr[15:0];
		else if (mode == 2'h1) w = ID_WORD;
		else w = 16'hC3C3 ^ addr[15:0];
		return byte_mode ? {~dq_out[15:8], w[7:0]} : w;
	endfunction
	// A deselected bus shows a changing pattern, never the last data.
	always @(ce_n, oe_n, addr, mode, byte_mode) begin
		if (!ce_n && !oe_n) dq_out <= #(T_ACC) rd_val();
		else dq_out <= #(T_ACC) ~dq_out;
	end
	always @(negedge we_n) t_fall = $realtime;
	always @(negedge oe_n) begin
		if ((!ce_n && !we_n) || (mode == 2'h2 && !byte_mode && addr[20:7] != 14'h0)) errs++;
	end
	always @(posedge we_n) begin
		if (!ce_n && oe_n && !lockout && ($realtime - t_fall) >= 5.0) begin
			if (dq_in[7:0] == 8'hF0) mode = (mode == 2'h2 && from_id) ? 2'h1 : 2'h0;
			else if (dq_in[7:0] == 8'h98 && addr == (byte_mode ? 21'h0000AA : 21'h000055) && mode != 2'h2) begin
				from_id = (mode == 2'h1);
				mode = 2'h2;
			end else mode = 2'h0;
		end
	end
	always @(posedge lockout) mode = 2'h0;
	always @(posedge ident_req) mode = 2'h1;
endmodule // fqh_flash_model

// *** testbench.sv ***
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin failures++; $display("wrong value at %0t: %h vs %h", $time, (a), (b)); end end
module testbench;
	import fqh_pkg::*;
	localparam logic [15:0] ID_W = 16'h1234; // Arbitrary identification word.
	localparam logic [7:0] QT [0:36] = '{8'h51, 8'h52, 8'h59, 8'h02, 8'h00, 8'h40, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h16, 8'h20, 8'h00, 8'h00, 8'h04, 8'h00, 8'h0A, 8'h00, 8'h05, 8'h00, 8'h04, 8'h00, 8'h15,
		8'h02, 8'h00, 8'h00, 8'h00, 8'h02, 8'hFF, 8'h01, 8'h10, 8'h00, 8'h1F, 8'h00, 8'h00, 8'h01};
	logic              ref_clk, arst_n, cmd_valid, byte_mode, ident_req, lockout;
	logic [1:0]        cmd_op;
	logic [6:0]        cmd_ofs;
	logic              cmd_ready, rsp_valid, rsp_match, ce_n, oe_n, we_n, dq_oe_n, qid;
	logic [15:0]       rsp_data, dq_o, dq_m, dq_bus;
	logic [ADDR_W-1:0] addr;
	int                failures, checked, errs, mode;
	assign dq_bus = !dq_oe_n ? dq_o : dq_m;
	fqh_host DUT (.ref_clk(ref_clk), .arst_n(arst_n), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_ofs(cmd_ofs),
		.byte_mode(byte_mode), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
		.rsp_match(rsp_match), .flash_addr(addr), .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n),
		.flash_dq_o(dq_o), .flash_dq_oe_n(dq_oe_n), .flash_dq_i(dq_bus));
	fqh_flash_model #(.ID_WORD(ID_W)) flash (.addr(addr), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .dq_in(dq_bus),
		.dq_out(dq_m), .byte_mode(byte_mode), .ident_req(ident_req), .lockout(lockout), .errs(errs));
	task automatic complete_run();
		if (failures == 0 && checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic wait_ready();
		int n;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (cmd_ready !== 1'b1 && n < 30);
		if (n >= 30) begin
			failures++;
			complete_run();
		end
	endtask
	task automatic issue(input logic [1:0] op, input logic [6:0] o, input logic bm);
		cmd_valid <= 1'b1;
		cmd_op <= op;
		cmd_ofs <= o;
		byte_mode <= bm;
		wait_ready();
		cmd_valid <= 1'b0;
	endtask
	task automatic wr(input logic [1:0] op, input logic bm);
		issue(op, 7'h00, bm);
		wait_ready();
		if (!lockout && op == OP_QUERY) begin
			qid = (mode == 1);
			mode = 2;
		end else if (!lockout) mode = (mode == 2 && qid) ? 1 : 0;
	endtask
	task automatic rd(input logic [6:0] o, input logic bm);
		logic [15:0] w;
		int n;
		w = mode == 2 ? {8'h00, QT[o - 7'h10]} : mode == 1 ? ID_W : 16'hC3C3 ^ (bm ? {8'h00, o, 1'b0} : {9'h000, o});
		if (bm) w[15:8] = 8'h00;
		issue(OP_READ, o, bm);
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (rsp_valid !== 1'b1 && n < 30);
		// The pulse set at the sixth edge is seen before the seventh edge's updates land.
		`CHK(n, 7)
		if (n >= 30) complete_run();
		`CHK(rsp_data, w)
		`CHK(rsp_match, w === {8'h00, QT[o - 7'h10]})
		wait_ready();
	endtask
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	initial begin
		arst_n = 1'b0;
		cmd_valid = 1'b0;
		cmd_op = 2'h0;
		cmd_ofs = 7'h00;
		byte_mode = 1'b0;
		ident_req = 1'b0;
		lockout = 1'b0;
		mode = 0;
		qid = 1'b0;
		repeat (16) @(posedge ref_clk);
		arst_n <= 1'b1;
		void'($urandom(98));
		`CHK({ce_n, oe_n, we_n, dq_oe_n, cmd_ready, rsp_valid}, 6'h3E)
		rd(7'h10, 1'b0);
		wr(OP_QUERY, 1'b0);
		for (int i = 16; i <= 52; i++) rd(7'(i), 1'b0);
		repeat (24) rd(7'(16 + $urandom_range(36)), 1'($urandom_range(1)));
		wr(OP_RESET, 1'b1);
		rd(7'h2D, 1'b0);
		wr(OP_QUERY, 1'b1);
		rd(7'h34, 1'b1);
		rd(7'h10, 1'b1);
		wr(OP_RESET, 1'b0);
		ident_req <= 1'b1;
		mode = 1;
		rd(7'h12, 1'b0);
		ident_req <= 1'b0;
		wr(OP_QUERY, 1'b0);
		rd(7'h11, 1'b0);
		wr(OP_RESET, 1'b0);
		rd(7'h11, 1'b0);
		wr(OP_RESET, 1'b0);
		rd(7'h11, 1'b0);
		wr(OP_QUERY, 1'b0);
		lockout <= 1'b1;
		mode = 0;
		rd(7'h10, 1'b0);
		wr(OP_QUERY, 1'b0);
		lockout <= 1'b0;
		rd(7'h10, 1'b0);
		`CHK(errs, 0)
		complete_run();
	end
endmodule // testbench
